/* src/audio_port_clocking_pkg.sv */
// Constants shared by the audio port clocking block.
`default_nettype none
package audio_port_clocking_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_FORMAT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RX_BASE = 8'h10;
  localparam logic [7:0] REG_TX_BASE = 8'h20;
  localparam logic [7:0] REG_LAST = 8'h2C;
  // Control bit positions.
  localparam int CTRL_SLAVE_BIT = 0;
  localparam int CTRL_BYPASS_BIT = 1;
  localparam int CTRL_SRC_PIN_BIT = 2;
  // Format field positions.
  localparam int FMT_IN_LSB = 0;
  localparam int FMT_OUT_LSB = 4;
  localparam int FMT_IN_WL_LSB = 8;
  localparam int FMT_OUT_WL_LSB = 10;
  // Reset values.
  localparam logic CTRL_SLAVE_RESET = 1'b0;
  localparam logic [3:0] FMT_RESET = 4'h2;
  localparam logic [1:0] WL_RESET = 2'h3;
  // ----------------------------------------
  // Format and word-length codes
  // ----------------------------------------
  localparam logic [3:0] FMT_LEFT_JUSTIFIED = 4'h0;
  localparam logic [3:0] FMT_RIGHT_JUSTIFIED = 4'h1;
  localparam logic [3:0] FMT_I2S = 4'h2;
  localparam logic [1:0] WL_16 = 2'h1;
  localparam logic [1:0] WL_20 = 2'h2;
  localparam logic [1:0] WL_24 = 2'h3;
  localparam int SAMPLE_BITS = 24;
  localparam logic [5:0] SLOT_BITS = 6'h20;
  // ----------------------------------------
  // Clock ratios and rates
  // ----------------------------------------
  localparam longint PCLK_HZ = 25000000;
  localparam longint FS_HZ = 48000;
  localparam int DSP_RATIO = 2816;
  localparam int MCU_RATIO = 704;
  localparam int CTRL_RATIO = 256;
  localparam int TICK_RATIO = 512;
  localparam logic [15:0] DSP_PER_CTRL = 16'(DSP_RATIO / CTRL_RATIO);
  localparam logic [17:0] MCU_QUARTERS_PER_CTRL = 18'((MCU_RATIO * 4) / CTRL_RATIO);
  localparam int NCO_BITS = 24;
  localparam logic [23:0] NCO_INC = 24'((FS_HZ * TICK_RATIO * (64'd1 << NCO_BITS)) / PCLK_HZ);
  localparam logic [8:0] FRAME_LAST = 9'h1FF;
  localparam logic [2:0] BIT_RISE_PHASE = 3'h3;
  localparam logic [2:0] BIT_FALL_PHASE = 3'h7;
endpackage
`default_nettype wire

/* src/audio_port_clocking.sv */
// Clock management and serial audio port front end with an APB register file.
`default_nettype none
// How it works
// - Core clocks from master clock, PLL or bypass.
// - Processing core runs 2816 cycles per frame.
// - Microcontroller runs 704 cycles per frame.
// - Serial control core runs 256 per frame.
// - Port starts as clock master after reset.
// - Master frame clock is 48 kHz.
// - Master bit clock is 64 per frame.
// - Master clock output is 256 per frame.
// - Master input sampled on internal port clocks.
// - Slave passes bit, frame clocks through.
// - Slave divides master clock for converters.
// - Rate changes keep registers and operation.
// - Four-bit format codes: LJ, RJ, I2S.
// - Four channels, two lanes, 16/20/24 bits.
// - Output framed by output clocks, same rate.
// - I2S: left low, MSB one bit late.
// - Right-justified: LSB ends each half frame.
// - Launch on falling, sample on rising edge.
module audio_port_clocking
  import audio_port_clocking_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_input,
  input wire logic mclk_in,
  input wire logic sclk_in,
  input wire logic lrclk_in,
  input wire logic serial_data_in_a,
  input wire logic serial_data_in_b,
  output logic mclk_out,
  output logic sclk_out,
  output logic lrclk_out,
  output logic serial_data_out_a,
  output logic serial_data_out_b,
  output logic converter_clk_tick,
  output logic [15:0] dsp_cycle_count,
  output logic [15:0] mcu_cycle_count,
  output logic [15:0] ctrl_cycle_count
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Synchroniser slots: crystal, master clock pin, bit clock, frame clock, lane a, lane b.
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] filt;
    logic [23:0] nco;
    logic [8:0] frame_cnt;
    logic slave;
    logic bypass;
    logic src_pin;
    logic [3:0] in_fmt;
    logic [3:0] out_fmt;
    logic [1:0] in_wl;
    logic [1:0] out_wl;
    logic [3:0][23:0] rx;
    logic [3:0][23:0] tx;
    logic [1:0][23:0] shift;
    logic [5:0] bitpos;
    logic last_lr;
    logic mclk_out;
    logic sclk_out;
    logic lrclk_out;
    logic sd_out_a;
    logic sd_out_b;
    logic conv_tick;
    logic [15:0] dsp_cnt;
    logic [17:0] mcu_q;
    logic [15:0] ctrl_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

  state_s st;
  state_s next_st;
  logic setup;
  logic wr_access;
  logic wr_format;

  // Length of a sample from its word-length code; a reserved code never reaches here.
  function automatic logic [5:0] wl_len(input logic [1:0] code);
    case (code)
      WL_16: wl_len = 6'd16;
      WL_20: wl_len = 6'd20;
      default: wl_len = 6'd24;
    endcase
  endfunction

  // First slot position of the MSB for a given framing.
  function automatic logic [5:0] fmt_start(input logic [3:0] fmt, input logic [5:0] len);
    case (fmt)
      FMT_I2S: fmt_start = 6'd1;
      FMT_RIGHT_JUSTIFIED: fmt_start = SLOT_BITS - len;
      default: fmt_start = 6'd0;
    endcase
  endfunction

  // Right channel flag: I2S puts right on a high frame clock, the others on low.
  function automatic logic is_right(input logic [3:0] fmt, input logic lr);
    is_right = (fmt == FMT_I2S) ? lr : ~lr;
  endfunction

  // True for a defined framing code.
  function automatic logic fmt_ok(input logic [3:0] fmt);
    fmt_ok = (fmt == FMT_LEFT_JUSTIFIED) || (fmt == FMT_RIGHT_JUSTIFIED) || (fmt == FMT_I2S);
  endfunction

  // Bus phase decode shared by the process and the checks.
  assign setup = psel && !penable;
  assign wr_access = st.pready && psel && penable && pwrite;
  assign wr_format = wr_access && (paddr == REG_FORMAT);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // All behaviour lives here; the register process below only stores it.
  always_comb
  begin
    logic [5:0] agree, k, kn, len, start, j;
    logic [24:0] nco_sum;
    logic src_sel, m_rise, t512, ctrl_tick, b_rise, b_fall, lr_now, lr_next;
    logic [1:0] ch;
    logic [4:0] bi;
    logic [23:0] word;
    next_st = st;
    {agree, k, kn, len, start, j} = 36'h0;
    nco_sum = 25'h0;
    {src_sel, m_rise, t512, ctrl_tick, b_rise, b_fall, lr_now, lr_next} = 8'h0;
    ch = 2'h0;
    bi = 5'h0;
    word = 24'h0;

    // Pin inputs: three stages, a change is taken once stages two and three agree.
    next_st.sync1 = {serial_data_in_b, serial_data_in_a, lrclk_in, sclk_in, mclk_in, crystal_input};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    agree = ~(st.sync2 ^ st.sync3);
    next_st.filt = (agree & st.sync3) | (~agree & st.filt);

    // Slave mode always runs from the master clock pin; master mode picks crystal or pin.
    src_sel = st.slave || st.src_pin;
    m_rise = src_sel ? (!st.filt[1] && next_st.filt[1]) : (!st.filt[0] && next_st.filt[0]);

    // The digital PLL is a phase accumulator making one tick per 512th of a frame.
    nco_sum = {1'b0, st.nco} + {1'b0, NCO_INC};
    next_st.nco = nco_sum[23:0];
    t512 = (st.slave || st.bypass) ? m_rise : nco_sum[24];

    // Frame counter; bit zero halves the tick, so it doubles as the 256x master clock.
    if (t512)
    begin
      next_st.frame_cnt = st.frame_cnt + 9'h1;
    end
    ctrl_tick = t512 && st.frame_cnt[0];
    next_st.conv_tick = ctrl_tick;

    // Core clocks are counted as cycles advanced per 256x tick.
    if (ctrl_tick)
    begin
      next_st.dsp_cnt = st.dsp_cnt + DSP_PER_CTRL;
      next_st.mcu_q = st.mcu_q + MCU_QUARTERS_PER_CTRL;
      next_st.ctrl_cnt = st.ctrl_cnt + 16'h1;
    end

    // Port clocks: generated in master mode; slave mode passes bit and frame clocks through, master clock output still from the frame counter.
    next_st.mclk_out = next_st.frame_cnt[0];
    if (st.slave)
    begin
      next_st.sclk_out = next_st.filt[2];
      next_st.lrclk_out = next_st.filt[3];
      b_rise = !st.filt[2] && next_st.filt[2];
      b_fall = st.filt[2] && !next_st.filt[2];
      lr_now = st.filt[3];
      lr_next = next_st.filt[3];
    end
    else
    begin
      next_st.sclk_out = next_st.frame_cnt[2];
      next_st.lrclk_out = next_st.frame_cnt[8];
      b_rise = t512 && (st.frame_cnt[2:0] == BIT_RISE_PHASE);
      b_fall = t512 && (st.frame_cnt[2:0] == BIT_FALL_PHASE);
      lr_now = st.frame_cnt[8];
      lr_next = next_st.frame_cnt[8];
    end

    // Receive: slot position restarts on each frame clock change, data taken on the rising edge.
    if (b_rise)
    begin
      k = (lr_now != st.last_lr) ? 6'h0 : st.bitpos + 6'h1;
      next_st.bitpos = k;
      next_st.last_lr = lr_now;
      len = wl_len(st.in_wl);
      start = fmt_start(st.in_fmt, len);
      ch = {1'b0, is_right(st.in_fmt, lr_now)};
      if ((k >= start) && (k < start + len))
      begin
        next_st.shift[0] = {st.shift[0][22:0], st.filt[4]};
        next_st.shift[1] = {st.shift[1][22:0], st.filt[5]};
      end
      // Samples are kept MSB-aligned; trailing or leading slot bits are simply not taken.
      if (k == start + len - 6'h1)
      begin
        next_st.rx[ch] = next_st.shift[0] << (6'd24 - len);
        next_st.rx[ch + 2'h2] = next_st.shift[1] << (6'd24 - len);
      end
    end

    // Transmit: the bit for the next rising edge is launched on the falling edge.
    if (b_fall)
    begin
      kn = (lr_next != st.last_lr) ? 6'h0 : st.bitpos + 6'h1;
      len = wl_len(st.out_wl);
      start = fmt_start(st.out_fmt, len);
      ch = {1'b0, is_right(st.out_fmt, lr_next)};
      j = kn - start;
      bi = 5'(6'd23 - j);
      if ((kn >= start) && (kn < start + len))
      begin
        word = st.tx[ch];
        next_st.sd_out_a = word[bi];
        word = st.tx[ch + 2'h2];
        next_st.sd_out_b = word[bi];
      end
      else
      begin
        next_st.sd_out_a = 1'b0;
        next_st.sd_out_b = 1'b0;
      end
    end

    // APB: answer in the cycle after setup, with read data and error prepared then.
    next_st.pready = setup;
    next_st.pslverr = 1'b0;
    if (setup)
    begin
      next_st.prdata = 32'h0;
      if (paddr[1:0] != 2'h0 || paddr > REG_LAST || (paddr > REG_STATUS && paddr < REG_RX_BASE))
      begin
        next_st.pslverr = 1'b1;
      end
      else if (paddr == REG_CONTROL)
      begin
        next_st.prdata = {29'h0, st.src_pin, st.bypass, st.slave};
      end
      else if (paddr == REG_FORMAT)
      begin
        next_st.prdata = {20'h0, st.out_wl, st.in_wl, st.out_fmt, st.in_fmt};
      end
      else if (paddr == REG_STATUS)
      begin
        next_st.prdata = {18'h0, st.bitpos, 5'h0, st.lrclk_out, st.sclk_out, st.slave};
      end
      else if (paddr < REG_TX_BASE)
      begin
        next_st.prdata = {8'h0, st.rx[paddr[3:2]]};
      end
      else
      begin
        next_st.prdata = {8'h0, st.tx[paddr[3:2]]};
      end
    end

    // Writes land on the access edge; mode and rate changes never clear other registers.
    if (wr_access && !st.pslverr)
    begin
      if (paddr == REG_CONTROL)
      begin
        next_st.slave = pwdata[CTRL_SLAVE_BIT];
        next_st.bypass = pwdata[CTRL_BYPASS_BIT];
        next_st.src_pin = pwdata[CTRL_SRC_PIN_BIT];
      end
      if (wr_format)
      begin
        if (fmt_ok(pwdata[FMT_IN_LSB +: 4]))
        begin
          next_st.in_fmt = pwdata[FMT_IN_LSB +: 4];
        end
        if (fmt_ok(pwdata[FMT_OUT_LSB +: 4]))
        begin
          next_st.out_fmt = pwdata[FMT_OUT_LSB +: 4];
        end
        if (pwdata[FMT_IN_WL_LSB +: 2] != 2'h0)
        begin
          next_st.in_wl = pwdata[FMT_IN_WL_LSB +: 2];
        end
        if (pwdata[FMT_OUT_WL_LSB +: 2] != 2'h0)
        begin
          next_st.out_wl = pwdata[FMT_OUT_WL_LSB +: 2];
        end
      end
      if (paddr >= REG_TX_BASE && paddr <= REG_LAST)
      begin
        next_st.tx[paddr[3:2]] = pwdata[23:0];
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // The clock enable freezes everything, the bus included, so a frozen block never half-answers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.slave <= CTRL_SLAVE_RESET;
      st.in_fmt <= FMT_RESET;
      st.out_fmt <= FMT_RESET;
      st.in_wl <= WL_RESET;
      st.out_wl <= WL_RESET;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign mclk_out = st.mclk_out;
  assign sclk_out = st.sclk_out;
  assign lrclk_out = st.lrclk_out;
  assign serial_data_out_a = st.sd_out_a;
  assign serial_data_out_b = st.sd_out_b;
  assign converter_clk_tick = st.conv_tick;
  assign dsp_cycle_count = st.dsp_cnt;
  assign mcu_cycle_count = st.mcu_q[17:2];
  assign ctrl_cycle_count = st.ctrl_cnt;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_dsp_step;
    @(posedge pclk) disable iff (!presetn) (clk_en && next_st.conv_tick) |=> (dsp_cycle_count == $past(dsp_cycle_count) + 16'd11);
  endproperty
  a_dsp_step: assert property (p_dsp_step) else $error("dsp count step wrong");

  property p_mcu_step;
    @(posedge pclk) disable iff (!presetn) (clk_en && next_st.conv_tick) |=> (st.mcu_q == $past(st.mcu_q) + 18'd11);
  endproperty
  a_mcu_step: assert property (p_mcu_step) else $error("mcu count step wrong");

  property p_ctrl_tick_ratio;
    @(posedge pclk) disable iff (!presetn) (clk_en && st.slave && !st.filt[1] && next_st.filt[1] && st.frame_cnt[0]) |=> converter_clk_tick && ctrl_cycle_count == $past(ctrl_cycle_count) + 16'd1;
  endproperty
  a_ctrl_tick_ratio: assert property (p_ctrl_tick_ratio) else $error("slave converter divide wrong");

  property p_master_after_reset;
    @(posedge pclk) $rose(presetn) |-> !st.slave;
  endproperty
  a_master_after_reset: assert property (p_master_after_reset) else $error("not master after reset");

  property p_frame_edge;
    @(posedge pclk) disable iff (!presetn) (clk_en && !st.slave && !next_st.slave && st.frame_cnt == 9'h0FF && next_st.frame_cnt == 9'h100) |=> $rose(lrclk_out);
  endproperty
  a_frame_edge: assert property (p_frame_edge) else $error("frame clock edge misplaced");

  property p_bit_clock;
    @(posedge pclk) disable iff (!presetn) (clk_en && !st.slave && !next_st.slave) |=> (sclk_out == st.frame_cnt[2] && mclk_out == st.frame_cnt[0]);
  endproperty
  a_bit_clock: assert property (p_bit_clock) else $error("master clocks not from frame counter");

  property p_passthrough;
    @(posedge pclk) disable iff (!presetn) (clk_en && st.slave && next_st.slave) |=> (sclk_out == st.filt[2] && lrclk_out == st.filt[3]);
  endproperty
  a_passthrough: assert property (p_passthrough) else $error("slave clocks not passed through");

  property p_reserved_kept;
    @(posedge pclk) disable iff (!presetn) (clk_en && wr_format && !fmt_ok(pwdata[3:0])) |=> $stable(st.in_fmt);
  endproperty
  a_reserved_kept: assert property (p_reserved_kept) else $error("reserved format accepted");

  property p_launch_on_fall;
    @(posedge pclk) disable iff (!presetn) (clk_en && !st.slave && st.frame_cnt[2:0] != BIT_FALL_PHASE) |=> $stable(serial_data_out_a);
  endproperty
  a_launch_on_fall: assert property (p_launch_on_fall) else $error("data launched off the falling edge");

  property p_rate_keeps_regs;
    @(posedge pclk) disable iff (!presetn) (clk_en && !wr_access) |=> ($stable(st.tx) && $stable(st.in_fmt) && $stable(st.out_wl));
  endproperty
  a_rate_keeps_regs: assert property (p_rate_keeps_regs) else $error("register changed without a write");

endmodule
`default_nettype wire

/* test/audio_source_model.sv */
// Behavioural far-side model: external clock source and serial audio sender.
`default_nettype none
module audio_source_model
(
  input wire logic en,
  input wire logic rate_441,
  input wire logic [23:0] smp,
  output logic mclk,
  output logic sclk,
  output logic lrclk,
  output logic data_a,
  output logic data_b,
  output logic crystal
);
  timeunit 1ns;
  timeprecision 1ps;
  int half;

  // Bit clock half period is eight times this many nanoseconds; the slower rate stands in for 44.1 kHz.
  always_comb half = rate_441 ? 174 : 160;

  // I2S slot content: MSB one bit after the frame clock edge, right channel inverted.
  function automatic logic slot_bit(input int s, input logic [23:0] v, input logic old);
    if (s % 32 >= 1 && s % 32 <= 24)
      return (s >= 32) ? ~v[24 - s % 32] : v[24 - s % 32];
    return ~old;
  endfunction

  // The crystal is an oscillator, so it runs free even between frames.
  initial
  begin
    crystal = 1'b0;
    forever #160 crystal = ~crystal;
  end

  // Master clock at 512 per 48 kHz frame; it stands still while idle.
  // Its frequency never changes during a run, so a rate switch needs no reset of the device.
  always
  begin
    mclk = 1'b0;
    wait (en);
    while (en)
    begin
      #160 mclk = 1'b1;
      #160 mclk = 1'b0;
    end
  end

  // Bit clock at 64 per frame, data changed with each falling bit clock edge.
  always
  begin
    sclk = 1'b0;
    lrclk = 1'b0;
    data_a = 1'b1; // Pulled-up data lines idle high.
    data_b = 1'b1;
    wait (en);
    while (en)
      for (int s = 0; s < 64; s++)
      begin
        lrclk = s[5];
        data_a = slot_bit(s, smp, data_a);
        data_b = slot_bit(s, smp ^ 24'h5A5A5A, data_b);
        #(8 * half) sclk = 1'b1;
        #(8 * half) sclk = 1'b0;
      end
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking testbench for the audio port clocking block.
`default_nettype none
`define CHK(n, e, g) compare(n, 32'(e), 32'(g))
module testbench
  import audio_port_clocking_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] TX_A = 24'hB4C3D2;
  localparam logic [23:0] TX_B = 24'h2D5A96;
  localparam logic [23:0] RX_SMP = 24'hC5A361;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic src_en = 1'b0;
  logic rate_441 = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, crystal_input, mclk_in, sclk_in, lrclk_in, sdi_a, sdi_b;
  logic mclk_out, sclk_out, lrclk_out, sdo_a, sdo_b, converter_clk_tick;
  logic [15:0] dsp_cycle_count, mcu_cycle_count, ctrl_cycle_count;
  logic [3:0] fmts [3] = '{FMT_LEFT_JUSTIFIED, FMT_RIGHT_JUSTIFIED, FMT_I2S};
  logic [1:0] wls [3] = '{WL_16, WL_20, WL_24};
  int num_errors = 0;
  int checked = 0;

  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  always #20 pclk = ~pclk;

  audio_port_clocking u_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_input(crystal_input), .mclk_in(mclk_in), .sclk_in(sclk_in),
    .lrclk_in(lrclk_in), .serial_data_in_a(sdi_a), .serial_data_in_b(sdi_b),
    .mclk_out(mclk_out), .sclk_out(sclk_out), .lrclk_out(lrclk_out),
    .serial_data_out_a(sdo_a), .serial_data_out_b(sdo_b), .converter_clk_tick(converter_clk_tick),
    .dsp_cycle_count(dsp_cycle_count), .mcu_cycle_count(mcu_cycle_count),
    .ctrl_cycle_count(ctrl_cycle_count)
  );

  audio_source_model u_src (
    .en(src_en), .rate_441(rate_441), .smp(RX_SMP), .mclk(mclk_in), .sclk(sclk_in),
    .lrclk(lrclk_in), .data_a(sdi_a), .data_b(sdi_b), .crystal(crystal_input)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_up(input string name);
    num_errors++;
    $display("wrong value %s expected done seen timeout", name);
    final_report();
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    // Read at the rising edge before the design's registers move, so ready, data and error are those of that edge.
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      give_up("pready");
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] r;
    logic e;
    apb(1'b1, addr, data, r, e);
    `CHK("write error", 1'b0, e);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp,
                        input logic [31:0] mask, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, addr, 32'h0, r, e);
    `CHK(name, exp & mask, r & mask);
    `CHK(name, exp_err, e);
  endtask

  task automatic wait_lr(input logic lvl);
    int n;
    n = 0;
    while (lrclk_out !== lvl && n < 10000)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 10000)
      give_up("frame clock");
  endtask

  // Counts port clock edges and counter steps over one whole output frame.
  task automatic measure(output int ns, output int nm, output int nt, output int np,
                         output logic [15:0] dd, output logic [15:0] dm, output logic [15:0] dc);
    logic s0, m0, l0, done;
    logic [15:0] a, b, c;
    wait_lr(1'b0);
    wait_lr(1'b1);
    {a, b, c} = {dsp_cycle_count, mcu_cycle_count, ctrl_cycle_count};
    {s0, m0, l0} = {sclk_out, mclk_out, 1'b1};
    {ns, nm, nt, np} = {32'd0, 32'd0, 32'd0, 32'd0};
    do
    begin
      @(negedge pclk);
      np++;
      ns += int'(sclk_out && !s0);
      nm += int'(mclk_out && !m0);
      nt += int'(converter_clk_tick === 1'b1);
      done = lrclk_out && !l0;
      {s0, m0, l0} = {sclk_out, mclk_out, lrclk_out};
    end
    while (!done && np < 20000);
    if (!done)
      give_up("frame");
    dd = dsp_cycle_count - a;
    dm = mcu_cycle_count - b;
    dc = ctrl_cycle_count - c;
  endtask

  // Captures the left slot of both output lanes and compares it bit for bit.
  task automatic tx_frame(input logic [3:0] fmt, input logic [1:0] wl);
    int len, msb, k, n;
    logic [31:0] exp_a, exp_b, got_a, got_b;
    logic s0, left;
    len = (wl == WL_16) ? 16 : (wl == WL_20) ? 20 : 24;
    msb = (fmt == FMT_LEFT_JUSTIFIED) ? 0 : (fmt == FMT_I2S) ? 1 : 32 - len;
    left = (fmt != FMT_I2S);
    {exp_a, exp_b, got_a, got_b} = '0;
    for (int i = 0; i < len; i++)
      {exp_a[31 - msb - i], exp_b[31 - msb - i]} = {TX_A[23 - i], TX_B[23 - i]};
    wr_reg(REG_FORMAT, {20'h0, wl, wl, fmt, fmt});
    wait_lr(!left);
    wait_lr(left);
    {s0, k, n} = {sclk_out, 32'd0, 32'd0};
    while (k < 32 && n < 2000)
    begin
      @(negedge pclk);
      n++;
      if (sclk_out && !s0)
      begin
        {got_a[31 - k], got_b[31 - k]} = {sdo_a, sdo_b};
        k++;
      end
      s0 = sclk_out;
    end
    `CHK("left slot lane a", exp_a, got_a);
    `CHK("left slot lane b", exp_b, got_b);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    rd_chk("control", REG_CONTROL, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd_chk("format", REG_FORMAT, 32'h0F22, 32'hFFFFFFFF, 1'b0);
    rd_chk("status slave", REG_STATUS, 32'h0, 32'h1, 1'b0);
    rd_chk("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
    rd_chk("misaligned", 8'h06, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr_reg(REG_TX_BASE, {8'h00, TX_A});
    wr_reg(REG_TX_BASE + 8'h08, {8'h00, TX_B});
    rd_chk("tx a left", REG_TX_BASE, {8'h00, TX_A}, 32'hFFFFFFFF, 1'b0);
    $display("test reset done");
  endtask

  task automatic test_master;
    int ns, nm, nt, np;
    logic [15:0] dd, dm, dc;
    measure(ns, nm, nt, np, dd, dm, dc);
    `CHK("bit clocks per frame", 64, ns);
    `CHK("master clocks per frame", 256, nm);
    `CHK("converter ticks per frame", 256, nt);
    `CHK("frame length", 1'b1, np >= 519 && np <= 523);
    `CHK("dsp cycles", 2816, dd);
    `CHK("mcu cycles", 704, dm);
    `CHK("ctrl cycles", 256, dc);
    $display("test master done");
  endtask

  task automatic test_formats;
    foreach (fmts[f])
      foreach (wls[w])
        tx_frame(fmts[f], wls[w]);
    // Reserved codes in every field must leave the framing as it was.
    wr_reg(REG_FORMAT, 32'h00F3);
    rd_chk("format kept", REG_FORMAT, 32'h0F22, 32'hFFFFFFFF, 1'b0);
    tx_frame(FMT_I2S, WL_24);
    $display("test formats done");
  endtask

  task automatic test_bypass;
    int nc, nt, n;
    logic c0;
    {nc, nt, n} = {32'd0, 32'd0, 32'd0};
    wr_reg(REG_CONTROL, 32'h2);
    c0 = crystal_input;
    while (nc < 64 && n < 5000)
    begin
      @(negedge pclk);
      n++;
      nc += int'(crystal_input && !c0);
      nt += int'(converter_clk_tick === 1'b1);
      c0 = crystal_input;
    end
    `CHK("bypass ticks", 1'b1, nt >= 31 && nt <= 33);
    wr_reg(REG_CONTROL, 32'h0);
    $display("test bypass done");
  endtask

  task automatic test_slave;
    int ns, nm, nt, np;
    logic [15:0] dd, dm, dc;
    src_en <= 1'b1;
    wr_reg(REG_CONTROL, 32'h5);
    measure(ns, nm, nt, np, dd, dm, dc);
    `CHK("slave bit clocks", 64, ns);
    `CHK("slave converter ticks", 1'b1, nt >= 255 && nt <= 257);
    rd_chk("status slave", REG_STATUS, 32'h1, 32'h1, 1'b0);
    rd_chk("rx a left", REG_RX_BASE, {8'h00, RX_SMP}, 32'hFFFFFFFF, 1'b0);
    rd_chk("rx a right", REG_RX_BASE + 8'h04, {8'h00, ~RX_SMP}, 32'hFFFFFFFF, 1'b0);
    rd_chk("rx b left", REG_RX_BASE + 8'h08, {8'h00, RX_SMP ^ 24'h5A5A5A}, 32'hFFFFFFFF, 1'b0);
    // The host switches rate while the master clock pin keeps its frequency.
    wr_reg(REG_CONTROL, 32'h1);
    rate_441 <= 1'b1;
    measure(ns, nm, nt, np, dd, dm, dc);
    measure(ns, nm, nt, np, dd, dm, dc);
    `CHK("slower bit clocks", 64, ns);
    rd_chk("format kept", REG_FORMAT, 32'h0F22, 32'hFFFFFFFF, 1'b0);
    rd_chk("control kept", REG_CONTROL, 32'h1, 32'h7, 1'b0);
    rd_chk("rx after rate change", REG_RX_BASE, {8'h00, RX_SMP}, 32'hFFFFFFFF, 1'b0);
    $display("test slave done");
  endtask

  // Main sequence: reset held for twenty cycles, then every scenario in turn.
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_master();
    test_formats();
    test_bypass();
    test_slave();
    final_report();
  end
endmodule
`default_nettype wire
